// *** rtl/eeprom_cmd_engine.sv ***
/*
 * two-wire serial eeprom slave: device address decode, byte and page
 * write with page buffer, self-timed programming, ack polling, write
 * protect, current/random/sequential reads, id page, lock, serial number,
 * and an apb slave for status and serial number words.
 * assumes scl/sda/strap pins are asynchronous and that the bench resolves
 * the open-drain sda wire from sda_oe.
 */
`timescale 1ns/1ps
module eeprom_cmd_engine
   import eeprom_cmd_pkg::*;
#(
   parameter int WRITE_CYCLES = TWR_CYCLES
)
(
   input  wire logic        core_clk,          // core clock 20 mhz
   input  wire logic        nrst,              // async reset, active low
   input  wire logic        scl_in,            // serial clock pin
   input  wire logic        sda_in,            // serial data pin level
   output logic             sda_out,           // sda drive value (low)
   output logic             sda_oe,            // high while pulling sda low
   input  wire logic        write_control_pin, // high protects the array
   input  wire logic [2:0]  chip_sel,          // address strap pins
   input  wire logic        psel,              // apb select
   input  wire logic        penable,           // apb enable
   input  wire logic        pwrite,            // apb direction
   input  wire logic [7:0]  paddr,             // apb byte address
   input  wire logic [31:0] pwdata,            // apb write data
   output logic [31:0]      prdata,            // apb read data
   output logic             pready,            // apb ready
   output logic             pslverr            // apb error, unmapped
);
   import eeprom_cmd_pkg::*;

   logic [7:0]            mem [ARRAY_BYTES];
   logic [7:0]            id_page [PAGE_BYTES];
   logic [7:0]            page_buf [PAGE_BYTES];
   logic [31:0]           serial_reg [4];
   logic [PAGE_BYTES-1:0] buf_mask_reg;
   logic                  lock_pend_reg;
   logic                  id_locked_reg;
   logic [2:0]            scl_sync, sda_sync;
   logic [1:0]            wp_sync;
   logic [5:0]            cs_sync;
   link_state_t           state_reg, after_ack_reg;
   logic [3:0]            cnt_reg;
   logic [7:0]            shift_reg;
   logic [7:0]            addr_reg;
   logic [7:0]            waddr_reg;
   logic                  special_reg;
   logic                  ack_seen_reg;
   logic                  got_data_reg;
   logic [PROG_CNT_W-1:0] prog_cnt_reg;
   logic                  sda_oe_reg;
   logic [31:0]           prdata_reg;
   logic                  pready_reg, pslverr_reg;

   logic scl_rise, scl_fall, start_seen, stop_seen, wp;
   assign scl_rise   = scl_sync[1] & ~scl_sync[2];
   assign scl_fall   = ~scl_sync[1] & scl_sync[2];
   assign start_seen = scl_sync[1] & scl_sync[2] & ~sda_sync[1] & sda_sync[2];
   assign stop_seen  = scl_sync[1] & scl_sync[2] & sda_sync[1] & ~sda_sync[2];
   assign wp         = wp_sync[1];

   assign sda_oe  = sda_oe_reg;
   assign prdata  = prdata_reg;
   assign pready  = pready_reg;
   assign pslverr = pslverr_reg;

   // byte seen by the master for a given space and pointer
   function automatic logic [7:0] fetch(input logic sp,
                                        input logic [7:0] a);
      logic [31:0] w;
      w = serial_reg[a[3:2]];
      if (!sp)
         fetch = mem[a];
      else if (a[7:6] == SEL_ID)
         fetch = id_page[a[3:0]];
      else if (a[7:6] == SEL_SERIAL)
         fetch = w[{a[1:0], 3'h0} +: 8];
      else
         fetch = UNDEF_BYTE;
   endfunction

   // pointer advance after a read byte
   function automatic logic [7:0] next_addr(input logic sp,
                                            input logic [7:0] a);
      if (sp)
         next_addr = {a[7:4], a[3:0] + 4'h1};
      else
         next_addr = a + 8'h01;
   endfunction

   // pin synchronisers, first stage feeds only the second
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         scl_sync <= 3'h7;
         sda_sync <= 3'h7;
         wp_sync  <= 2'h0;
         cs_sync  <= 6'h00;
      end
      else
      begin
         scl_sync <= {scl_sync[1:0], scl_in};
         sda_sync <= {sda_sync[1:0], sda_in};
         wp_sync  <= {wp_sync[0], write_control_pin};
         cs_sync  <= {cs_sync[2:0], chip_sel};
      end
   end

   // sda is only ever pulled low
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         sda_out <= 1'b0;
      else
         sda_out <= 1'b0;
   end

   // link protocol engine
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state_reg     <= ST_IDLE;
         after_ack_reg <= ST_IDLE;
         cnt_reg       <= 4'h0;
         shift_reg     <= 8'h00;
         addr_reg      <= 8'h00;
         waddr_reg     <= 8'h00;
         special_reg   <= 1'b0;
         ack_seen_reg  <= 1'b0;
         got_data_reg  <= 1'b0;
         buf_mask_reg  <= '0;
         lock_pend_reg <= 1'b0;
         prog_cnt_reg  <= '0;
         sda_oe_reg    <= 1'b0;
      end
      else if (state_reg == ST_PROG)
      begin
         sda_oe_reg <= 1'b0;
         if (prog_cnt_reg >= PROG_CNT_W'(WRITE_CYCLES - 1))
         begin
            state_reg    <= ST_IDLE;
            prog_cnt_reg <= '0;
         end
         else
            prog_cnt_reg <= prog_cnt_reg + 1'b1;
      end
      else if (stop_seen)
      begin
         sda_oe_reg   <= 1'b0;
         got_data_reg <= 1'b0;
         buf_mask_reg <= '0;
         lock_pend_reg <= 1'b0;
         if (got_data_reg && (buf_mask_reg != '0 || lock_pend_reg))
            state_reg <= ST_PROG;
         else
            state_reg <= ST_IDLE;
      end
      else if (start_seen)
      begin
         sda_oe_reg   <= 1'b0;
         state_reg    <= ST_DEV;
         cnt_reg      <= 4'h0;
         got_data_reg <= 1'b0;
         buf_mask_reg <= '0;
         lock_pend_reg <= 1'b0;
      end
      else
      begin
         case (state_reg)
            ST_DEV, ST_WADDR, ST_WDATA:
            begin
               if (scl_rise && cnt_reg < 4'h8)
               begin
                  shift_reg <= {shift_reg[6:0], sda_sync[1]};
                  cnt_reg   <= cnt_reg + 4'h1;
               end
               else if (scl_fall && cnt_reg == 4'h8)
               begin
                  cnt_reg <= 4'h0;
                  if (state_reg == ST_DEV)
                  begin
                     if ((shift_reg[7:4] == TYPE_MAIN ||
                          shift_reg[7:4] == TYPE_SPECIAL) &&
                         shift_reg[3:1] == cs_sync[5:3])
                     begin
                        sda_oe_reg  <= 1'b1;
                        state_reg   <= ST_ACK;
                        special_reg <= (shift_reg[7:4] == TYPE_SPECIAL);
                        after_ack_reg <= shift_reg[0] ? ST_TX
                                                      : ST_WADDR;
                     end
                     else
                        state_reg <= ST_IDLE;
                  end
                  else if (state_reg == ST_WADDR)
                  begin
                     waddr_reg     <= shift_reg;
                     addr_reg      <= shift_reg;
                     sda_oe_reg    <= 1'b1;
                     state_reg     <= ST_ACK;
                     after_ack_reg <= ST_WDATA;
                  end
                  else if (special_reg && addr_reg[LOCK_ADDR_BIT])
                  begin
                     // lock command byte
                     if (shift_reg[LOCK_DATA_BIT] && !id_locked_reg)
                     begin
                        lock_pend_reg <= 1'b1;
                        got_data_reg  <= 1'b1;
                     end
                     sda_oe_reg    <= 1'b1;
                     state_reg     <= ST_ACK;
                     after_ack_reg <= ST_WDATA;
                  end
                  else if (special_reg && id_locked_reg)
                     state_reg <= ST_IDLE;
                  else
                  begin
                     if (special_reg ? addr_reg[7:6] == SEL_ID
                                     : !wp)
                     begin
                        page_buf[addr_reg[3:0]] <= shift_reg;
                        buf_mask_reg[addr_reg[3:0]] <= 1'b1;
                     end
                     got_data_reg  <= 1'b1;
                     addr_reg      <= {addr_reg[7:4],
                                       addr_reg[3:0] + 4'h1};
                     sda_oe_reg    <= 1'b1;
                     state_reg     <= ST_ACK;
                     after_ack_reg <= ST_WDATA;
                  end
               end
            end
            ST_ACK:
            begin
               if (scl_fall)
               begin
                  cnt_reg <= 4'h0;
                  if (after_ack_reg == ST_TX)
                  begin
                     shift_reg  <= fetch(special_reg, addr_reg);
                     sda_oe_reg <= 1'(~fetch(special_reg, addr_reg) >> 7);
                     addr_reg   <= next_addr(special_reg, addr_reg);
                     state_reg  <= ST_TX;
                  end
                  else
                  begin
                     sda_oe_reg <= 1'b0;
                     state_reg  <= after_ack_reg;
                  end
               end
            end
            ST_TX:
            begin
               if (scl_rise)
                  cnt_reg <= cnt_reg + 4'h1;
               else if (scl_fall)
               begin
                  if (cnt_reg == 4'h8)
                  begin
                     sda_oe_reg <= 1'b0;
                     state_reg  <= ST_RACK;
                  end
                  else
                  begin
                     shift_reg  <= {shift_reg[6:0], 1'b0};
                     sda_oe_reg <= ~shift_reg[6];
                  end
               end
            end
            ST_RACK:
            begin
               if (scl_rise)
                  ack_seen_reg <= ~sda_sync[1];
               else if (scl_fall)
               begin
                  cnt_reg <= 4'h0;
                  if (ack_seen_reg)
                  begin
                     shift_reg  <= fetch(special_reg, addr_reg);
                     sda_oe_reg <= 1'(~fetch(special_reg, addr_reg) >> 7);
                     addr_reg   <= next_addr(special_reg, addr_reg);
                     state_reg  <= ST_TX;
                  end
                  else
                     state_reg <= ST_IDLE;
               end
            end
            ST_IDLE:
               sda_oe_reg <= 1'b0;
            default:
            begin
               sda_oe_reg <= 1'b0;
               state_reg  <= ST_IDLE;
            end
         endcase
      end
   end

   // nonvolatile commit at the write stop
   always_ff @(posedge core_clk)
   begin
      if (nrst && state_reg != ST_PROG && stop_seen && got_data_reg)
      begin
         for (int i = 0; i < PAGE_BYTES; i++)
         begin
            if (buf_mask_reg[i])
            begin
               if (special_reg)
                  id_page[i] <= page_buf[i];
               else
                  mem[{waddr_reg[7:4], 4'(i)}] <= page_buf[i];
            end
         end
      end
   end

   // lock state
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         id_locked_reg <= 1'b0;
      else if (state_reg != ST_PROG && stop_seen && lock_pend_reg)
         id_locked_reg <= 1'b1;
   end

   // apb slave: status and serial number words
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         pready_reg    <= 1'b0;
         pslverr_reg   <= 1'b0;
         prdata_reg    <= 32'h00000000;
         serial_reg[0] <= SERIAL_RESET0;
         serial_reg[1] <= SERIAL_RESET1;
         serial_reg[2] <= SERIAL_RESET2;
         serial_reg[3] <= SERIAL_RESET3;
      end
      else
      begin
         pready_reg <= psel & ~penable;
         if (psel && !penable)
         begin
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h00000000;
            if (paddr == OFS_STATUS)
            begin
               prdata_reg[ST_BUSY_BIT] <= (state_reg == ST_PROG);
               prdata_reg[ST_LOCK_BIT] <= id_locked_reg;
               prdata_reg[ST_WP_BIT]   <= wp;
               prdata_reg[ST_ADDR_LSB +: ADDR_W] <= addr_reg;
            end
            else if (paddr >= OFS_SERIAL0 && paddr <= OFS_SERIAL3 &&
                     paddr[1:0] == 2'h0)
               prdata_reg <= serial_reg[paddr[3:2]];
            else
               pslverr_reg <= 1'b1;
         end
         if (psel && penable && pready_reg && pwrite && !pslverr_reg &&
             paddr >= OFS_SERIAL0)
            serial_reg[paddr[3:2]] <= pwdata;
      end
   end
endmodule

// *** rtl/eeprom_cmd_pkg.sv ***
/*
 * constants for the two-wire eeprom command engine: device type codes,
 * word address fields, apb register map and the write cycle timing.
 * assumes a 20 mhz core clock and a 256 x 8 main array.
 */
package eeprom_cmd_pkg;
   localparam logic [3:0]  TYPE_MAIN    = 4'ha;   // 1010b main array
   localparam logic [3:0]  TYPE_SPECIAL = 4'hb;   // 1011b id/lock/serial
   localparam int          ADDR_W       = 8;
   localparam int          ARRAY_BYTES  = 256;
   localparam int          PAGE_BYTES   = 16;
   localparam logic [1:0]  SEL_ID       = 2'h0;   // word addr [7:6]
   localparam logic [1:0]  SEL_SERIAL   = 2'h2;
   localparam int          LOCK_ADDR_BIT = 6;
   localparam int          LOCK_DATA_BIT = 1;
   localparam logic [7:0]  UNDEF_BYTE   = 8'hff;

   // apb register byte offsets
   localparam logic [7:0]  OFS_STATUS   = 8'h00;
   localparam logic [7:0]  OFS_SERIAL0  = 8'h10;
   localparam logic [7:0]  OFS_SERIAL3  = 8'h1c;
   localparam int          ST_BUSY_BIT  = 0;
   localparam int          ST_LOCK_BIT  = 1;
   localparam int          ST_WP_BIT    = 2;
   localparam int          ST_ADDR_LSB  = 8;
   // serial number reset words: arbitrary neutral values
   localparam logic [31:0] SERIAL_RESET0 = 32'h00000001;
   localparam logic [31:0] SERIAL_RESET1 = 32'h00000002;
   localparam logic [31:0] SERIAL_RESET2 = 32'h00000003;
   localparam logic [31:0] SERIAL_RESET3 = 32'h00000004;

   // self-timed write cycle, longest time rounds down
   localparam int          CLK_HZ       = 20_000_000;
   localparam int          TWR_MS       = 5;
   localparam int          TWR_CYCLES   = TWR_MS * (CLK_HZ / 1000);
   localparam int          PROG_CNT_W   = 17;

   typedef enum logic [3:0] {
      ST_IDLE, ST_DEV, ST_WADDR, ST_WDATA, ST_ACK, ST_TX, ST_RACK, ST_PROG
   } link_state_t;
endpackage

// *** test/twi_master_model.sv ***
/* two-wire bus master model: start, stop, byte out and byte in.
   assumes the bench resolves sda from sda_low, a pull-up and the device. */
`timescale 1ns/1ps
module twi_master_model
(
   input  wire logic sda_wire, // resolved data line
   output logic      scl,      // serial clock, still between frames
   output logic      sda_low   // high while the master pulls sda low
);
   initial
   begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   // start or repeated start, sda falls while scl is high
   task automatic start_cond();
      #13 sda_low = 1'b0;
      #100 scl = 1'b1;
      #100 sda_low = 1'b1;
      #100 scl = 1'b0;
      #100;
   endtask
   task automatic stop_cond();
      sda_low = 1'b1;
      #100 scl = 1'b1;
      #100 sda_low = 1'b0;
      #100;
   endtask
   // data changes only while scl is low
   task automatic clk_bit(input logic b, output logic s);
      sda_low = ~b;
      #100 scl = 1'b1;
      #100 s = sda_wire;
      #100 scl = 1'b0;
      #100;
   endtask
   task automatic send_byte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
         clk_bit(d[i], s);
      clk_bit(1'b1, s);
      ack = ~s;
   endtask
   task automatic recv_byte(input logic ack, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--)
      begin
         clk_bit(1'b1, s);
         d[i] = s;
      end
      clk_bit(~ack, s);
   endtask
endmodule

// *** test/eeprom_cmd_engine_sva.sv ***
/* checker for the eeprom engine: apb handshake and sda drive timing.
   assumes it is bound into the engine and sees only its ports. */
`timescale 1ns/1ps
module eeprom_link_checker
   import eeprom_cmd_pkg::*;
(
   input wire logic       core_clk, // core clock
   input wire logic       nrst,     // async reset, active low
   input wire logic       scl_in,   // serial clock pin
   input wire logic       sda_out,  // sda drive value
   input wire logic       sda_oe,   // sda pull enable
   input wire logic       psel,     // apb select
   input wire logic       penable,  // apb enable
   input wire logic       pwrite,   // apb direction
   input wire logic [7:0] paddr,    // apb byte address
   input wire logic       pready,   // apb ready
   input wire logic       pslverr   // apb error
);
   logic mapped;
   assign mapped = paddr == OFS_STATUS || (paddr[1:0] == 2'h0
                   && paddr >= OFS_SERIAL0 && paddr <= OFS_SERIAL3);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!nrst);
   a_setup_ready: assert property (psel && !penable |=> pready)
      else $error("pready missing in first access cycle");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_ready_cause: assert property
      (pready |-> psel && penable && $past(psel && !penable))
      else $error("pready without a setup cycle");
   a_unmapped_err: assert property (pready && !mapped |-> pslverr)
      else $error("no error for unmapped address");
   a_mapped_ok: assert property (pready && mapped && !pwrite |-> !pslverr)
      else $error("error on a mapped read");
   a_ack_low: assert property (sda_oe |-> !sda_out)
      else $error("sda driven high");
   a_drive_scl_low: assert property ($rose(sda_oe) |-> !scl_in)
      else $error("sda pulled while scl high");
   a_free_scl_low: assert property ($fell(sda_oe) |-> !scl_in)
      else $error("sda released while scl high");
   a_steady_high: assert property
      (scl_in && $past(scl_in) |-> $stable(sda_oe))
      else $error("sda drive changed during scl high");
   c_refused: cover property (pready && pslverr);
   c_ack_seen: cover property ($rose(sda_oe));
   c_reg_write: cover property (pready && pwrite && mapped);
endmodule
bind eeprom_cmd_engine eeprom_link_checker chk (.core_clk, .nrst, .scl_in,
   .sda_out, .sda_oe, .psel, .penable, .pwrite, .paddr, .pready, .pslverr);

// *** test/i2c_eeprom_command_engine_tb_top.sv ***
/* bench top for the two-wire eeprom engine: apb and link scenarios.
   assumes the master model and the checker are compiled before it. */
`timescale 1ns/1ps
module i2c_eeprom_command_engine_tb_top;
   import eeprom_cmd_pkg::*;
   logic        core_clk, nrst, write_control_pin, psel, penable, pwrite;
   logic [2:0]  chip_sel;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic        pready, pslverr, sda_out, sda_oe, sda_low, scl, sda_wire;
   int          errors, n_checks;
   logic [7:0]  mem [256];
   logic [7:0]  q [$];
   logic [7:0]  none [$];
   logic [31:0] sn [4];
   // pull-up: released line reads high
   assign sda_wire = sda_low ? 1'b0 : (sda_oe ? sda_out : 1'b1);
   twi_master_model m (.sda_wire(sda_wire), .scl(scl), .sda_low(sda_low));
   eeprom_cmd_engine #(.WRITE_CYCLES(200)) dut
   (
      .core_clk(core_clk), .nrst(nrst), .scl_in(scl), .sda_in(sda_wire),
      .sda_out(sda_out), .sda_oe(sda_oe),
      .write_control_pin(write_control_pin), .chip_sel(chip_sel),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
   );
   initial
   begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic timeout_hit();
      errors++;
      complete_run();
   endtask
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   function automatic logic [7:0] ser_byte(input int i);
      return sn[(i % 16) / 4][8 * (i % 4) +: 8];
   endfunction
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic er);
      int n;
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge core_clk);
      penable <= 1'b1;
      for (n = 0; n < 20; n++)
      begin
         @(posedge core_clk);
         if (pready === 1'b1)
            break;
      end
      if (n == 20)
         timeout_hit();
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr_seq(input logic [3:0] t, input logic [7:0] a,
                         input logic [7:0] dq [$], input logic dack,
                         input logic fin);
      logic ak;
      m.start_cond();
      m.send_byte({t, chip_sel, 1'b0}, ak);
      check("device ack", 32'(ak), 32'h1);
      m.send_byte(a, ak);
      check("word ack", 32'(ak), 32'h1);
      foreach (dq[i])
      begin
         m.send_byte(dq[i], ak);
         check("data ack", 32'(ak), 32'(dack));
      end
      if (fin)
         m.stop_cond();
   endtask
   task automatic rd_at(input logic [3:0] t, input logic [7:0] a,
                        input logic dummy, input int n);
      logic       ak;
      logic [7:0] d;
      if (dummy)
         wr_seq(t, a, none, 1'b1, 1'b0);
      m.start_cond();
      m.send_byte({t, chip_sel, 1'b1}, ak);
      check("read ack", 32'(ak), 32'h1);
      q = {};
      for (int i = 0; i < n; i++)
      begin
         m.recv_byte(i < n - 1, d);
         q.push_back(d);
      end
      m.stop_cond();
   endtask
   task automatic poll(output int n);
      logic ak;
      for (n = 0; n < 40; n++)
      begin
         m.start_cond();
         m.send_byte({TYPE_MAIN, chip_sel, 1'b0}, ak);
         m.stop_cond();
         if (ak === 1'b1)
            break;
      end
      if (n == 40)
         timeout_hit();
   endtask
   initial
   begin
      logic [7:0]  d;
      logic [31:0] rd;
      logic        er;
      int          n;
      {nrst, psel, penable, pwrite, write_control_pin} = 5'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      errors = 0;
      n_checks = 0;
      void'($urandom(26912));
      chip_sel = 3'($urandom);
      sn = '{SERIAL_RESET0, SERIAL_RESET1, SERIAL_RESET2, SERIAL_RESET3};
      repeat (5) @(posedge core_clk);
      nrst <= 1'b1;
      apb(1'b0, OFS_STATUS, 32'h0, rd, er);
      check("status", rd & 32'hff07, 32'h0);
      for (int i = 0; i < 4; i++)
      begin
         apb(1'b0, OFS_SERIAL0 + 8'(4 * i), 32'h0, rd, er);
         check("serial reset", rd, sn[i]);
         sn[i] = $urandom;
         apb(1'b1, OFS_SERIAL0 + 8'(4 * i), sn[i], rd, er);
         apb(1'b0, OFS_SERIAL0 + 8'(4 * i), 32'h0, rd, er);
         check("serial word", rd, sn[i]);
      end
      apb(1'b0, 8'h40, 32'h0, rd, er);
      check("unmapped", 32'(er), 32'h1);
      $display("test apb done");
      d = 8'($urandom);
      mem[0] = d;
      q = {d};
      wr_seq(TYPE_MAIN, 8'h00, q, 1'b1, 1'b1);
      poll(n);
      check("busy polls", 32'(n > 0 && n < 5), 32'h1);
      q = {};
      for (int k = 0; k < 18; k++)
      begin
         q.push_back(8'($urandom));
         mem[8'hf0 | 8'((14 + k) % 16)] = q[k];
      end
      wr_seq(TYPE_MAIN, 8'hfe, q, 1'b1, 1'b1);
      poll(n);
      rd_at(TYPE_MAIN, 8'hf0, 1'b1, 16);
      for (int i = 0; i < 16; i++)
         check("page byte", 32'(q[i]), 32'(mem[8'hf0 + 8'(i)]));
      rd_at(TYPE_MAIN, 8'h00, 1'b0, 1);
      check("current read", 32'(q[0]), 32'(mem[0]));
      $display("test array done");
      write_control_pin <= 1'b1;
      repeat (4) @(posedge core_clk);
      apb(1'b0, OFS_STATUS, 32'h0, rd, er);
      check("protect flag", 32'(rd[ST_WP_BIT]), 32'h1);
      q = {~d};
      wr_seq(TYPE_MAIN, 8'h00, q, 1'b1, 1'b1);
      poll(n);
      check("no programming", 32'(n), 32'h0);
      rd_at(TYPE_MAIN, 8'h00, 1'b1, 1);
      check("protected byte", 32'(q[0]), 32'(mem[0]));
      write_control_pin <= 1'b0;
      $display("test protect done");
      d = 8'($urandom);
      q = {d};
      wr_seq(TYPE_SPECIAL, 8'h35, q, 1'b1, 1'b1);
      poll(n);
      rd_at(TYPE_SPECIAL, 8'h25, 1'b1, 1);
      check("id byte", 32'(q[0]), 32'(d));
      q = {d};
      wr_seq(TYPE_SPECIAL, 8'h05, q, 1'b1, 1'b1);
      poll(n);
      q = {8'($urandom) | 8'h02};
      wr_seq(TYPE_SPECIAL, 8'($urandom) | 8'h40, q, 1'b1, 1'b1);
      poll(n);
      apb(1'b0, OFS_STATUS, 32'h0, rd, er);
      check("lock flag", 32'(rd[ST_LOCK_BIT]), 32'h1);
      q = {~d};
      wr_seq(TYPE_SPECIAL, 8'h05, q, 1'b0, 1'b1);
      poll(n);
      rd_at(TYPE_SPECIAL, 8'h05, 1'b1, 1);
      check("locked id", 32'(q[0]), 32'(d));
      $display("test id page done");
      rd_at(TYPE_SPECIAL, 8'h80, 1'b1, 17);
      for (int i = 0; i < 17; i++)
         check("serial byte", 32'(q[i]), 32'(ser_byte(i)));
      $display("test serial done");
      for (int i = 0; i < 2; i++)
      begin
         m.start_cond();
         m.send_byte({i ? 4'h9 : TYPE_MAIN, i ? chip_sel : ~chip_sel,
                      1'b0}, er);
         m.stop_cond();
         check("foreign address", 32'(er), 32'h0);
      end
      $display("test refusal done");
      complete_run();
   end
endmodule
